// >>> core/tchrp_pkg.sv
// Package of constants and carrier types for the time-code register port
package tchrp_pkg;
  localparam logic [1:0] OFS_INT_CTRL_STAT = 2'h0;
  localparam logic [1:0] OFS_RX_VID_STAT   = 2'h1;
  localparam logic [1:0] OFS_IND_ADDR      = 2'h2;
  localparam logic [1:0] OFS_IND_DATA      = 2'h3;
  localparam int         IND_REG_COUNT     = 64;
  localparam int         PTR_MSB           = 5;
  localparam int         POINTER_AUTO_INCREMENT_BIT       = 7;
  localparam int         RX_FRAME_BITS     = 64;
  localparam int         TX_LOAD_BITS      = 72;
  localparam int         TX_FRAME_BITS     = 80;
  localparam int         TIMER_WIDTH       = 10;
  localparam int         TICK_FREQ_KHZ     = 100;
  localparam int         CLK_FREQ_KHZ      = 25000;
  localparam int         TICK_DIV          = CLK_FREQ_KHZ / TICK_FREQ_KHZ;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  // Interrupt control/status layout: flags low nibble, enables high nibble
  localparam int         FLAG_RX     = 0;
  localparam int         FLAG_TX     = 1;
  localparam int         FLAG_VLINE  = 2;
  localparam int         FLAG_TIMER  = 3;
  localparam int         EN_SHIFT    = 4;
  // Status register layout
  localparam int         ST_FRAMEPIN = 0;
  localparam int         ST_CLICK    = 1;
  localparam int         ST_LOCK     = 2;
  localparam int         ST_DIR      = 3;
  localparam int         ST_VIDEO_GENLOCK_ACHIEVED    = 4;
  localparam int         ST_FIELD    = 6;
  localparam int         ST_FRAME    = 7;
  // Indirect register holding transmit enable (bit 0) and timer source (bits 2:1)
  localparam logic [5:0] IND_TX_CTRL = 6'h34;
  localparam logic [5:0] IND_TX_BASE = 6'h08;

  typedef enum logic [1:0] {
    TCHRP_TSRC_TICK = 2'b00,
    TCHRP_TSRC_RX   = 2'b01,
    TCHRP_TSRC_TX   = 2'b10
  } tchrp_tsrc_t;

  typedef struct packed {
    logic rx_bit;
    logic rx_fwd_sync;
    logic rx_bwd_sync;
    logic rx_sync_miss;
    logic rx_bad_bit;
    logic tx_bit;
    logic line_pass;
    logic colour_frame_pin_level;
    logic click_pin_level;
    logic video_genlock_achieved;
    logic field_even;
    logic colour_frame;
  } tchrp_events_t;

  typedef struct packed {
    logic       timecode_port_select_n;
    logic       serial_port_select_n;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [1:0] addr;
    logic [7:0] wdata;
  } tchrp_bus_t;
endpackage

// >>> core/tchrp_port.sv
// Host register port of the time-code receiver/generator
`timescale 1ns/10ps
// What this block does
// - Chip select and A1:A0 pick four registers
// - 64 indirect registers via data window only
// - Pointer is bits 5:0 of address register
// - Auto-increment advances pointer after window access
// - Interrupt when any flag and enable set
// - Reading interrupt register clears pending flags
// - Receive flag after 64th bit following sync
// - Transmit load after 72nd bit, flag in same cycle
// - Double buffer: post-flag writes go in N+2
// - Video line flag when chosen line passed
// - Timer flag on every expiry; enable gates only the interrupt
// - Ten-bit timer, three selectable count sources
// - Status shows colour-frame pin level
// - Status shows external click pin level
// - Lock set on sync, cleared on miss
// - Direction bit valid only while locked
// - Status shows video genlock achieved
// - Field parity bit 6, frame bit 7
// - Field/frame validity depends on line timing
// - Load receive buffer only after valid sync
// - Serial port registers use separate select
// - Interrupt request is active high
// - Master reset active high, restores registers
module tchrp_port #(
  parameter int IND_COUNT = tchrp_pkg::IND_REG_COUNT
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire tchrp_pkg::tchrp_bus_t   i_bus,
  input  wire tchrp_pkg::tchrp_events_t i_ev,
  input  wire logic [63:0]             i_rx_shift,
  output logic [7:0]                   o_rdata,
  output logic                         o_rdata_oe_n,
  output logic                         o_interrupt_request,
  output logic                         o_serial_port_rd,
  output logic                         o_serial_port_wr,
  output logic [63:0]                  o_tx_out_buffer,
  output logic                         o_transmitter_enable
);
  initial begin
    if (IND_COUNT != 64) $error("tchrp_port: only 64 indirect registers supported");
  end

  typedef struct packed {
    logic [IND_COUNT-1:0][7:0] ind;
    logic [7:0]                ptr;
    logic [3:0]                flags;
    logic [3:0]                en;
    logic                      lock;
    logic                      dir;
    logic [6:0]                rx_cnt;
    logic [6:0]                tx_cnt;
    logic                      rd_q;
    logic                      wr_q;
    logic [7:0]                rdata;
    logic                      oe_n;
    logic                      irq;
    logic                      srd;
    logic                      swr;
    logic [63:0]               tx_buf;
  } tchrp_state_t;

  tchrp_state_t st;
  tchrp_state_t next_st;
  logic         timer_expire;
  logic [7:0]   status_byte;
  logic         tc_sel;
  logic         rd_start;
  logic         wr_start;
  logic         rd_end;
  logic         wr_end;
  logic [3:0]   ev_set;
  logic [5:0]   idx;

  assign tc_sel   = ~i_bus.timecode_port_select_n;
  assign rd_start = tc_sel & ~i_bus.read_strobe_n & ~st.rd_q;
  assign wr_start = tc_sel & ~i_bus.write_strobe_n & ~st.wr_q;
  assign rd_end   = st.rd_q & i_bus.read_strobe_n;
  assign wr_end   = st.wr_q & i_bus.write_strobe_n;
  assign idx      = st.ptr[tchrp_pkg::PTR_MSB:0];

  tchrp_timer u_timer (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_src    (st.ind[tchrp_pkg::IND_TX_CTRL][2:1]),
    .i_reload (10'h3FF),
    .i_rx_bit (i_ev.rx_bit),
    .i_tx_bit (i_ev.tx_bit),
    .o_expire (timer_expire)
  );

  always_comb begin
    status_byte = 8'h00;
    status_byte[tchrp_pkg::ST_FRAMEPIN] = i_ev.colour_frame_pin_level;
    status_byte[tchrp_pkg::ST_CLICK]    = i_ev.click_pin_level;
    status_byte[tchrp_pkg::ST_LOCK]     = st.lock;
    status_byte[tchrp_pkg::ST_DIR]      = st.dir & st.lock;
    status_byte[tchrp_pkg::ST_VIDEO_GENLOCK_ACHIEVED]    = i_ev.video_genlock_achieved;
    // Upstream sync separator qualifies these by line number
    status_byte[tchrp_pkg::ST_FIELD]    = i_ev.field_even;
    status_byte[tchrp_pkg::ST_FRAME]    = i_ev.colour_frame;
  end

  always_comb begin
    next_st = st;
    ev_set = 4'h0;
    next_st.rd_q = tc_sel & ~i_bus.read_strobe_n;
    next_st.wr_q = tc_sel & ~i_bus.write_strobe_n;
    next_st.srd = ~i_bus.serial_port_select_n & ~i_bus.read_strobe_n;
    next_st.swr = ~i_bus.serial_port_select_n & ~i_bus.write_strobe_n;
    next_st.oe_n = ~(tc_sel & ~i_bus.read_strobe_n);

    // Receive lock and direction
    if (i_ev.rx_fwd_sync | i_ev.rx_bwd_sync) begin
      next_st.lock = 1'b1;
      next_st.dir = i_ev.rx_bwd_sync;
      next_st.rx_cnt = 7'h00;
    end else if (i_ev.rx_sync_miss | i_ev.rx_bad_bit) begin
      next_st.lock = 1'b0;
    end else if (i_ev.rx_bit && st.lock && st.rx_cnt != 7'h7F) begin
      next_st.rx_cnt = st.rx_cnt + 7'h01;
    end
    // Frame complete only after sync-qualified reception
    if (st.lock && i_ev.rx_bit && st.rx_cnt == 7'(tchrp_pkg::RX_FRAME_BITS - 1)) begin
      ev_set[tchrp_pkg::FLAG_RX] = 1'b1;
      for (int i = 0; i < 8; i++) begin
        next_st.ind[i] = i_rx_shift[i*8 +: 8];
      end
    end

    // Transmit bit count; frame boundary taken as 80 bits
    if (i_ev.tx_bit) begin
      next_st.tx_cnt = (st.tx_cnt == 7'(tchrp_pkg::TX_FRAME_BITS - 1)) ? 7'h00 : st.tx_cnt + 7'h01;
    end
    // Second buffer stage; host writes after this land two frames on
    if (o_transmitter_enable && i_ev.tx_bit && st.tx_cnt == 7'(tchrp_pkg::TX_LOAD_BITS - 1)) begin
      ev_set[tchrp_pkg::FLAG_TX] = 1'b1;
      for (int i = 0; i < 8; i++) begin
        next_st.tx_buf[i*8 +: 8] = st.ind[tchrp_pkg::IND_TX_BASE + 6'(i)];
      end
    end

    ev_set[tchrp_pkg::FLAG_VLINE] = i_ev.line_pass;
    ev_set[tchrp_pkg::FLAG_TIMER] = timer_expire;

    // Read data captured at strobe start
    if (rd_start) begin
      if (i_bus.addr == tchrp_pkg::OFS_INT_CTRL_STAT) begin
        next_st.rdata = {st.en, st.flags};
      end else if (i_bus.addr == tchrp_pkg::OFS_RX_VID_STAT) begin
        next_st.rdata = status_byte;
      end else if (i_bus.addr == tchrp_pkg::OFS_IND_ADDR) begin
        next_st.rdata = st.ptr;
      end else begin
        next_st.rdata = st.ind[idx];
      end
    end

    if (wr_start) begin
      if (i_bus.addr == tchrp_pkg::OFS_INT_CTRL_STAT) begin
        next_st.en = i_bus.wdata[7:4];
      end else if (i_bus.addr == tchrp_pkg::OFS_IND_ADDR) begin
        next_st.ptr = i_bus.wdata;
      end else if (i_bus.addr == tchrp_pkg::OFS_IND_DATA) begin
        next_st.ind[idx] = i_bus.wdata;
      end
    end

    // Pointer steps when the window access ends
    if ((rd_end || wr_end) && st.ptr[tchrp_pkg::POINTER_AUTO_INCREMENT_BIT]
        && i_bus.addr == tchrp_pkg::OFS_IND_DATA) begin
      next_st.ptr[tchrp_pkg::PTR_MSB:0] = idx + 6'h01;
    end

    // Clear on read, but a coincident event wins
    if (rd_start && i_bus.addr == tchrp_pkg::OFS_INT_CTRL_STAT) begin
      next_st.flags = ev_set;
    end else begin
      next_st.flags = st.flags | ev_set;
    end
    next_st.irq = |(next_st.flags & next_st.en);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata              = st.rdata;
  assign o_rdata_oe_n         = st.oe_n;
  assign o_interrupt_request  = st.irq;
  assign o_serial_port_rd     = st.srd;
  assign o_serial_port_wr     = st.swr;
  assign o_tx_out_buffer      = st.tx_buf;
  assign o_transmitter_enable = st.ind[tchrp_pkg::IND_TX_CTRL][0];

  a_irq_follows: assert property (@(posedge i_clk) disable iff (i_reset)
    ##1 o_interrupt_request == |($past(next_st.flags) & $past(next_st.en)))
    else $error("irq mismatch");
  a_read_clears: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_start && i_bus.addr == 2'h0 && ev_set == 4'h0) |=> st.flags == 4'h0)
    else $error("flags not cleared");
  a_event_kept: assert property (@(posedge i_clk) disable iff (i_reset)
    timer_expire |=> st.flags[3])
    else $error("event lost");
  a_ptr_inc: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_end && st.ptr[7] && i_bus.addr == 2'h3) |=> st.ptr[5:0] == $past(idx) + 6'h01)
    else $error("pointer not advanced");
  a_ptr_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (!wr_start && !st.ptr[7]) |=> st.ptr == $past(st.ptr))
    else $error("pointer moved");
  a_lock_set: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ev.rx_fwd_sync |=> st.lock && !st.dir)
    else $error("lock not set");
  a_lock_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ev.rx_bad_bit && !i_ev.rx_fwd_sync && !i_ev.rx_bwd_sync) |=> !st.lock)
    else $error("lock not cleared");
  a_serial_sel: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_bus.serial_port_select_n) |=> !o_serial_port_rd && !o_serial_port_wr)
    else $error("serial strobe without select");

  // Multi-step behaviours: the triggering cycle of each
  sequence s_rx_last_bit;
    st.lock && i_ev.rx_bit && st.rx_cnt == 7'(tchrp_pkg::RX_FRAME_BITS - 1);
  endsequence
  sequence s_tx_load;
    o_transmitter_enable && i_ev.tx_bit && st.tx_cnt == 7'(tchrp_pkg::TX_LOAD_BITS - 1);
  endsequence
  sequence s_status_read;
    rd_start && i_bus.addr == tchrp_pkg::OFS_RX_VID_STAT;
  endsequence
  sequence s_window_write;
    wr_start && i_bus.addr == tchrp_pkg::OFS_IND_DATA;
  endsequence
  sequence s_window_read;
    rd_start && i_bus.addr == tchrp_pkg::OFS_IND_DATA;
  endsequence
  sequence s_pointer_write;
    wr_start && i_bus.addr == tchrp_pkg::OFS_IND_ADDR;
  endsequence

  // Receive and transmit frame events
  a_rx_flag_set: assert property (@(posedge i_clk) disable iff (i_reset)
    s_rx_last_bit |=> st.flags[tchrp_pkg::FLAG_RX])
    else $error("receive flag not set");
  a_rx_load_data: assert property (@(posedge i_clk) disable iff (i_reset)
    s_rx_last_bit |=> st.ind[0] == $past(i_rx_shift[7:0]))
    else $error("receive buffer not loaded");
  a_rx_cnt_restart: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ev.rx_fwd_sync || i_ev.rx_bwd_sync) |=> st.rx_cnt == 7'h00)
    else $error("bit count not restarted on sync");
  a_rx_flag_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    (!st.lock && !st.flags[tchrp_pkg::FLAG_RX]) |=> !st.flags[tchrp_pkg::FLAG_RX])
    else $error("receive flag without lock");
  a_tx_flag_set: assert property (@(posedge i_clk) disable iff (i_reset)
    s_tx_load |=> st.flags[tchrp_pkg::FLAG_TX])
    else $error("transmit flag not set");
  a_tx_load_data: assert property (@(posedge i_clk) disable iff (i_reset)
    s_tx_load |=> o_tx_out_buffer[7:0] == $past(st.ind[tchrp_pkg::IND_TX_BASE]))
    else $error("output buffer not loaded");
  a_tx_buf_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_ev.tx_bit) |=> $stable(o_tx_out_buffer))
    else $error("output buffer changed between loads");
  a_tx_flag_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    (!o_transmitter_enable && !st.flags[tchrp_pkg::FLAG_TX]) |=> !st.flags[tchrp_pkg::FLAG_TX])
    else $error("transmit flag while disabled");
  a_lock_bwd: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ev.rx_bwd_sync |=> st.lock && st.dir)
    else $error("backward lock not set");

  // Other interrupt sources and the request line
  a_vline_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ev.line_pass |=> st.flags[tchrp_pkg::FLAG_VLINE])
    else $error("video line flag not set");
  a_vline_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_ev.line_pass && !st.flags[tchrp_pkg::FLAG_VLINE]) |=> !st.flags[tchrp_pkg::FLAG_VLINE])
    else $error("video line flag without event");
  a_timer_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    (!timer_expire && !st.flags[tchrp_pkg::FLAG_TIMER]) |=> !st.flags[tchrp_pkg::FLAG_TIMER])
    else $error("timer flag without expiry");
  a_irq_on: assert property (@(posedge i_clk) disable iff (i_reset)
    (|(next_st.flags & next_st.en)) |=> o_interrupt_request)
    else $error("interrupt request missing");
  a_irq_off: assert property (@(posedge i_clk) disable iff (i_reset)
    ((next_st.flags & next_st.en) == 4'h0) |=> !o_interrupt_request)
    else $error("interrupt request without enabled flag");
  a_enable_write: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_start && i_bus.addr == tchrp_pkg::OFS_INT_CTRL_STAT) |=> st.en == $past(i_bus.wdata[7:4]))
    else $error("enables not written");

  // Status register contents
  a_status_pin: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_FRAMEPIN] == $past(i_ev.colour_frame_pin_level))
    else $error("frame pin level wrong");
  a_status_click: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_CLICK] == $past(i_ev.click_pin_level))
    else $error("click pin level wrong");
  a_status_lock: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_LOCK] == $past(st.lock))
    else $error("lock bit wrong");
  a_dir_masked: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_start && i_bus.addr == tchrp_pkg::OFS_RX_VID_STAT && !st.lock) |=> !o_rdata[tchrp_pkg::ST_DIR])
    else $error("direction shown without lock");
  a_status_video_genlock_achieved: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_VIDEO_GENLOCK_ACHIEVED] == $past(i_ev.video_genlock_achieved))
    else $error("genlock bit wrong");
  a_status_field: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_FIELD] == $past(i_ev.field_even))
    else $error("field bit wrong");
  a_status_frame: assert property (@(posedge i_clk) disable iff (i_reset)
    s_status_read |=> o_rdata[tchrp_pkg::ST_FRAME] == $past(i_ev.colour_frame))
    else $error("frame bit wrong");

  // Register access
  a_ptr_write: assert property (@(posedge i_clk) disable iff (i_reset)
    s_pointer_write |=> st.ptr == $past(i_bus.wdata))
    else $error("pointer not written");
  a_win_write: assert property (@(posedge i_clk) disable iff (i_reset)
    s_window_write |=> st.ind[$past(idx)] == $past(i_bus.wdata))
    else $error("window write lost");
  a_win_read: assert property (@(posedge i_clk) disable iff (i_reset)
    s_window_read |=> o_rdata == $past(st.ind[idx]))
    else $error("window read wrong");
  a_status_ro: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_start && i_bus.addr == tchrp_pkg::OFS_RX_VID_STAT) |=> st.en == $past(st.en) && st.ptr == $past(st.ptr))
    else $error("status write had effect");
  a_rdata_stands: assert property (@(posedge i_clk) disable iff (i_reset)
    (!rd_start) |=> $stable(o_rdata))
    else $error("read data changed without read");
  a_oe_read: assert property (@(posedge i_clk) disable iff (i_reset)
    (tc_sel && !i_bus.read_strobe_n) |=> !o_rdata_oe_n)
    else $error("data not driven during read");
  a_oe_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !(tc_sel && !i_bus.read_strobe_n) |=> o_rdata_oe_n)
    else $error("data driven without read");
  a_serial_rd: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_bus.serial_port_select_n && !i_bus.read_strobe_n) |=> o_serial_port_rd)
    else $error("serial read strobe missing");
endmodule

// >>> core/tchrp_timer.sv
// Interval timer with selectable count source
`timescale 1ns/10ps
module tchrp_timer #(
  parameter int WIDTH = tchrp_pkg::TIMER_WIDTH,
  parameter int DIV   = tchrp_pkg::TICK_DIV
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [1:0]       i_src,
  input  wire logic [WIDTH-1:0] i_reload,
  input  wire logic             i_rx_bit,
  input  wire logic             i_tx_bit,
  output logic                  o_expire
);
  initial begin
    if (WIDTH < 2 || DIV < 1) $error("tchrp_timer: bad parameters");
  end

  typedef struct packed {
    logic [15:0]      pre;
    logic [WIDTH-1:0] cnt;
    logic             expire;
  } tchrp_tmr_t;

  tchrp_tmr_t st;
  tchrp_tmr_t next_st;
  logic       step;

  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    step = 1'b0;
    if (st.pre == 16'(DIV - 1)) begin
      next_st.pre = 16'h0000;
    end else begin
      next_st.pre = st.pre + 16'h0001;
    end
    case (i_src)
      tchrp_pkg::TCHRP_TSRC_TICK: step = (st.pre == 16'(DIV - 1));
      tchrp_pkg::TCHRP_TSRC_RX:   step = i_rx_bit;
      tchrp_pkg::TCHRP_TSRC_TX:   step = i_tx_bit;
      default:                    step = 1'b0;
    endcase
    // Counts up from zero so the first expiry after reset takes a full period
    if (step) begin
      if (st.cnt == i_reload) begin
        next_st.cnt = '0;
        next_st.expire = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_expire = st.expire;
endmodule

// >>> tb/tb_timecode_host_register_port.sv
// Self-checking bench for the time-code host register port
`timescale 1ns/10ps
module tb_timecode_host_register_port;
  logic                     i_clk;
  logic                     i_reset;
  tchrp_pkg::tchrp_bus_t    bus;
  tchrp_pkg::tchrp_events_t ev;
  logic [7:0]               rdata;
  logic                     irq;
  logic [63:0]              txb;
  logic                     txen;
  logic [7:0]               q;
  logic                     oen;
  logic                     srd;
  logic                     swr;
  logic                     oe_seen = 1'b0;
  logic                     srd_seen = 1'b0;
  logic                     swr_seen = 1'b0;
  int                       n_mismatch;
  int                       samples_checked;
  int                       cyc = 0;

  tchrp_host host (.i_clk(i_clk), .i_rdata(rdata), .o_bus(bus));
  tchrp_port dut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .i_ev(ev),
    .i_rx_shift(64'h0123456789ABCDEF), .o_rdata(rdata), .o_rdata_oe_n(oen), .o_interrupt_request(irq),
    .o_serial_port_rd(srd), .o_serial_port_wr(swr), .o_tx_out_buffer(txb), .o_transmitter_enable(txen));

  // Strobe outputs last only a few cycles, so remember that they were seen
  always @(posedge i_clk) begin
    if (oen == 1'b0) oe_seen <= 1'b1;
    if (srd == 1'b1) srd_seen <= 1'b1;
    if (swr == 1'b1) swr_seen <= 1'b1;
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host.acc(1'b0, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic [1:0] a);
    host.acc(1'b0, 1'b0, a, 8'h00, q);
  endtask
  task automatic pulse(input tchrp_pkg::tchrp_events_t p, input int n);
    repeat (n) begin
      @(posedge i_clk);
      ev <= ev | p;
      @(posedge i_clk);
      ev <= ev & ~p;
    end
    repeat (3) @(posedge i_clk);
  endtask
  task automatic t_reset;
    rd(2'h0);
    chk(q, 8'h00);
    chk(oe_seen, 1'b1);
    chk(irq, 1'b0);
    rd(2'h2);
    chk(q, 8'h00);
    chk(oen, 1'b1);
  endtask
  // Run right after t_reset so the slow tick source has not yet advanced the count
  task automatic t_timer;
    wr(2'h2, 8'h34);
    wr(2'h3, 8'h02);
    wr(2'h0, 8'h80);
    pulse(12'h800, 1000);
    chk(irq, 1'b0);
    pulse(12'h800, 30);
    chk(irq, 1'b1);
    rd(2'h0);
    chk(q, 8'h88);
    chk(irq, 1'b0);
  endtask
  task automatic t_status;
    @(posedge i_clk);
    ev <= ev | 12'h01F;
    pulse(12'h200, 1);
    rd(2'h1);
    chk(q, 8'hDF);
    pulse(12'h080, 1);
    rd(2'h1);
    chk(q, 8'hD3);
    ev <= ev & ~12'h01F;
    rd(2'h1);
    chk(q, 8'h00);
  endtask
  task automatic t_indirect;
    wr(2'h2, 8'h88);
    for (int i = 0; i < 8; i++) wr(2'h3, 8'h10 + i[7:0]);
    wr(2'h2, 8'h08);
    rd(2'h3);
    rd(2'h3);
    chk(q, 8'h10);
    wr(2'h2, 8'h89);
    for (int i = 1; i < 8; i++) begin
      rd(2'h3);
      chk(q, 8'h10 + i[7:0]);
    end
    rd(2'h2);
    chk(q, 8'h90);
    wr(2'h2, 8'hBF);
    rd(2'h3);
    rd(2'h2);
    chk(q, 8'h80);
  endtask
  task automatic t_tx;
    wr(2'h2, 8'h34);
    wr(2'h3, 8'h01);
    chk(txen, 1'b1);
    pulse(12'h040, 71);
    chk(txb, 64'h0);
    pulse(12'h040, 1);
    chk(txb, 64'h1716151413121110);
    rd(2'h0);
    chk(q, 8'h82);
    wr(2'h2, 8'h08);
    wr(2'h3, 8'hAA);
    pulse(12'h040, 79);
    chk(txb[7:0], 8'h10);
    pulse(12'h040, 1);
    chk(txb[7:0], 8'hAA);
    pulse(12'h040, 80);
    chk(txb[7:0], 8'hAA);
  endtask
  task automatic t_irq;
    wr(2'h0, 8'h40);
    rd(2'h0);
    pulse(12'h020, 1);
    chk(irq, 1'b1);
    rd(2'h0);
    chk(q, 8'h44);
    chk(irq, 1'b0);
    wr(2'h0, 8'h00);
    pulse(12'h020, 1);
    chk(irq, 1'b0);
    host.acc(1'b1, 1'b0, 2'h0, 8'h00, q);
    chk(srd_seen, 1'b1);
    chk(swr_seen, 1'b0);
    host.acc(1'b1, 1'b1, 2'h0, 8'hF0, q);
    chk(swr_seen, 1'b1);
    rd(2'h0);
    chk(q, 8'h04);
  endtask
  task automatic t_rx;
    pulse(12'h400, 1);
    pulse(12'h800, 63);
    rd(2'h0);
    chk(q[0], 1'b0);
    pulse(12'h800, 1);
    rd(2'h0);
    chk(q[0], 1'b1);
    wr(2'h2, 8'h00);
    rd(2'h3);
    chk(q, 8'hEF);
  endtask
  task automatic results;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    ev = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset;
    t_timer;
    t_status;
    t_indirect;
    t_tx;
    t_irq;
    t_rx;
    results;
  end
  always #20 i_clk = ~i_clk;
  // Whole run needs about 3000 cycles; the ceiling leaves ample margin
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
  end
endmodule

// >>> tb/tchrp_host.sv
// Host processor model driving the parallel register bus
`timescale 1ns/10ps
module tchrp_host (
  input  wire logic            i_clk,
  input  wire logic [7:0]      i_rdata,
  output tchrp_pkg::tchrp_bus_t o_bus
);
  initial o_bus = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
  // One access: one select and one strobe low, held two edges, then released
  task automatic acc(input logic ser, input logic wr, input logic [1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_clk);
    o_bus <= '{ser, ~ser, wr, ~wr, a, d};
    @(posedge i_clk);
    #1 q = i_rdata;
    @(posedge i_clk);
    // Released data lines show the inverse so a stale value cannot pass
    o_bus <= '{1'b1, 1'b1, 1'b1, 1'b1, a, ~d};
    repeat (2) @(posedge i_clk);
  endtask
endmodule
